// ==== hdl/sad_decoder.sv ====
/*
  System address decoder: SRAM aliases, Flash bank placement, bridge windows.
  Assumes the requester holds the request stable and that a full write queue
  is reported on wq_full_i from logic on the same clock.
*/
`timescale 1ns/1ps
`include "sad_regs.svh"

module sad_decoder
  import sad_pkg::*;
(
  input  wire logic          clk_i,        // 50 MHz system clock
  input  wire logic          resetn_i,     // Async reset, active low
  input  wire logic          ce_i,         // Clock enable
  input  wire sad_req_type   req_i,        // Access request
  input  wire logic          wq_full_i,    // Write queue full
  input  wire logic [1:0]    sram_code_i,  // SRAM size code 0/1/2
  input  wire logic          sram_load_i,  // Strobe for sram_code_i
  input  wire sad_bank_type  bank1_cfg_i,  // Primary bank setup
  input  wire sad_bank_type  bank2_cfg_i,  // Secondary bank setup
  input  wire logic          bank_load_i,  // Strobe for bank setups
  input  wire logic          nv_boot_i,    // Stored boot choice pin
  output sad_route_type      route_o,      // Registered decode result
  output logic               stall_o,      // Cpu stall
  output logic               boot_second_o // Boot choice in use
);

  // --------------------------------------------------------------------------
  // Boot choice
  // --------------------------------------------------------------------------
  logic boot_second;

  sad_boot_select sad_boot_select_inst (
    .clk_i         (clk_i),
    .resetn_i      (resetn_i),
    .ce_i          (ce_i),
    .nv_bit_i      (nv_boot_i),
    .boot_second_o (boot_second)
  );

  // --------------------------------------------------------------------------
  // Configuration state
  // --------------------------------------------------------------------------
  logic [1:0]   sram_code_reg;
  logic [1:0]   sram_code_next;
  sad_bank_type bank1_reg;
  sad_bank_type bank1_next;
  sad_bank_type bank2_reg;
  sad_bank_type bank2_next;
  logic         init_reg;
  logic         init_next;
  logic [1:0]   wait_reg;
  logic [1:0]   wait_next;
  logic         boot_out_reg;

  // Bank placement follows the boot choice until firmware reprograms it
  always_comb begin
    sram_code_next = sram_code_reg;
    bank1_next     = bank1_reg;
    bank2_next     = bank2_reg;
    wait_next      = (wait_reg == `SAD_INIT_WAIT) ? wait_reg : wait_reg + 2'h1;
    init_next      = (wait_reg == `SAD_INIT_WAIT);
    if (!init_reg) begin
      // Boot bit settles three edges after release; placement tracks it until then
      bank1_next.enable = !boot_second;
      bank1_next.base   = boot_second ? `SAD_FLASH2_BASE_RST : `SAD_BOOT_BASE;
      bank2_next.enable = boot_second;
      bank2_next.base   = boot_second ? `SAD_BOOT_BASE : `SAD_FLASH2_BASE_RST;
    end else if (bank_load_i) begin
      bank1_next = bank1_cfg_i;
      bank2_next = bank2_cfg_i;
    end
    if (sram_load_i && (sram_code_i != 2'h3)) begin
      sram_code_next = sram_code_i;
    end
  end

  // Registers only; init holds until the boot capture has settled
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sram_code_reg <= `SAD_SRAM_CODE_RST;
      bank1_reg     <= '{enable: 1'b1, base: `SAD_BOOT_BASE, size: `SAD_FLASH_SIZE_RST};
      bank2_reg     <= '{enable: 1'b0, base: `SAD_FLASH2_BASE_RST, size: `SAD_FLASH_SIZE_RST};
      wait_reg      <= 2'h0;
      init_reg      <= 1'b0;
      boot_out_reg  <= 1'b0;
    end else if (ce_i) begin
      sram_code_reg <= sram_code_next;
      bank1_reg     <= bank1_next;
      bank2_reg     <= bank2_next;
      wait_reg      <= wait_next;
      init_reg      <= init_next;
      boot_out_reg  <= boot_second;
    end
  end

  // --------------------------------------------------------------------------
  // Combinational decode
  // --------------------------------------------------------------------------
  logic [31:0]   sram_size;
  sad_route_type dec;
  logic [31:0]   rel1;
  logic [31:0]   rel2;

  always_comb begin
    case (sram_code_reg)
      2'h1:    sram_size = `SAD_SRAM_64K;
      2'h2:    sram_size = `SAD_SRAM_96K;
      default: sram_size = `SAD_SRAM_32K;
    endcase
  end

  always_comb begin
    rel1 = req_i.addr - bank1_reg.base;
    rel2 = req_i.addr - bank2_reg.base;
    dec            = '0;
    dec.valid      = req_i.valid;
    dec.target     = SAD_TGT_NONE;
    dec.error      = 1'b1;
    // Each bank compared separately: one may program while other reads
    if (bank1_reg.enable && (rel1 < bank1_reg.size)) begin
      dec.target = SAD_TGT_FLASH1;
      dec.offset = rel1;
      dec.error  = 1'b0;
    end else if (bank2_reg.enable && (rel2 < bank2_reg.size)) begin
      dec.target = SAD_TGT_FLASH2;
      dec.offset = rel2;
      dec.error  = 1'b0;
    end else if ((req_i.addr - `SAD_SRAM_TCM_BASE) < `SAD_WIN_SIZE) begin
      dec.offset     = req_i.addr - `SAD_SRAM_TCM_BASE;
      dec.target     = SAD_TGT_SRAM;
      dec.local_port = req_i.from_cpu;
      dec.error      = (dec.offset >= sram_size);
    end else if ((req_i.addr - `SAD_SRAM_BUF_BASE) < `SAD_WIN_SIZE) begin
      dec.offset   = req_i.addr - `SAD_SRAM_BUF_BASE;
      dec.target   = SAD_TGT_SRAM;
      dec.buffered = req_i.from_cpu;
      dec.error    = (dec.offset >= sram_size);
    end else if ((req_i.addr - `SAD_SRAM_NBUF_BASE) < `SAD_WIN_SIZE) begin
      dec.offset   = req_i.addr - `SAD_SRAM_NBUF_BASE;
      dec.target   = SAD_TGT_SRAM;
      dec.error    = (dec.offset >= sram_size);
    end else if (req_i.addr >= `SAD_BRG_BUF_BASE && req_i.addr <= `SAD_BRG_BUF_LAST) begin
      dec.offset   = req_i.addr - `SAD_BRG_BUF_BASE;
      dec.buffered = req_i.from_cpu;
      dec.error    = 1'b0;
    end else if (req_i.addr >= `SAD_BRG_NBUF_BASE && req_i.addr <= `SAD_BRG_NBUF_LAST) begin
      dec.offset   = req_i.addr - `SAD_BRG_NBUF_BASE;
      dec.error    = 1'b0;
    end
    // Bridge split: upper half of the window is the second bridge
    if (!dec.error && dec.target == SAD_TGT_NONE) begin
      if (dec.offset >= `SAD_BRG2_OFFSET) begin
        dec.target = SAD_TGT_BRG2;
        dec.offset = dec.offset - `SAD_BRG2_OFFSET;
      end else begin
        dec.target = SAD_TGT_BRG1;
      end
    end
    // Reads and non-cpu writes always go direct
    if (!req_i.write || !req_i.from_cpu) begin
      dec.buffered = 1'b0;
    end
    if (dec.error) begin
      dec.target     = SAD_TGT_NONE;
      dec.buffered   = 1'b0;
      dec.local_port = 1'b0;
      dec.offset     = '0;
    end
    if (!req_i.valid) begin
      dec = '0;
    end
  end

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  sad_route_type route_reg;
  logic          stall_reg;
  logic          stall_next;

  // A stalled buffered write is not issued until the queue has room
  always_comb begin
    stall_next = dec.valid && dec.buffered && wq_full_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      route_reg <= '0;
      stall_reg <= 1'b0;
    end else if (ce_i) begin
      route_reg <= stall_next ? sad_route_type'('0) : dec;
      stall_reg <= stall_next;
    end
  end

  assign route_o       = route_reg;
  assign stall_o       = stall_reg;
  assign boot_second_o = boot_out_reg;

endmodule

// ==== hdl/sad_regs.svh ====
/*
  Address map constants for the system address decoder.
  Assumes a 32-bit byte address space; included by bare name.
*/
`ifndef SAD_REGS_SVH
`define SAD_REGS_SVH

// ----------------------------------------------------------------------------
// Fixed windows
// ----------------------------------------------------------------------------
`define SAD_BOOT_BASE       32'h0000_0000
`define SAD_SRAM_TCM_BASE   32'h0400_0000
`define SAD_SRAM_BUF_BASE   32'h4000_0000
`define SAD_SRAM_NBUF_BASE  32'h5000_0000
`define SAD_BRG_BUF_BASE    32'h4800_0000
`define SAD_BRG_BUF_LAST    32'h4fff_ffff
`define SAD_BRG_NBUF_BASE   32'h5800_0000
`define SAD_BRG_NBUF_LAST   32'h5fff_ffff
`define SAD_BRG2_OFFSET     32'h0400_0000
`define SAD_WIN_SIZE        32'h0400_0000

// ----------------------------------------------------------------------------
// SRAM size codes and reset values
// ----------------------------------------------------------------------------
`define SAD_SRAM_32K        32'h0000_8000
`define SAD_SRAM_64K        32'h0001_0000
`define SAD_SRAM_96K        32'h0001_8000
`define SAD_SRAM_CODE_RST   2'h0
`define SAD_FLASH_SIZE_RST  32'h0000_8000
`define SAD_FLASH2_BASE_RST 32'h0008_0000

// ----------------------------------------------------------------------------
// Start-up timing after reset release
// ----------------------------------------------------------------------------
`define SAD_BOOT_CAP_AT     2'h2
`define SAD_INIT_WAIT       2'h3

`endif

// ==== hdl/sad_pkg.sv ====
/*
  Types for the system address decoder.
  Assumes sad_regs.svh is on the include path.
*/
package sad_pkg;

  // Where a decoded access lands
  typedef enum logic [3:0] {
    SAD_TGT_NONE   = 4'h0,
    SAD_TGT_SRAM   = 4'h1,
    SAD_TGT_FLASH1 = 4'h2,
    SAD_TGT_FLASH2 = 4'h3,
    SAD_TGT_BRG1   = 4'h4,
    SAD_TGT_BRG2   = 4'h5
  } sad_target_type;

  // Incoming access
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_cpu;
    logic [31:0] addr;
  } sad_req_type;

  // Decode result
  typedef struct packed {
    logic           valid;
    sad_target_type target;
    logic           local_port;
    logic           buffered;
    logic           error;
    logic [31:0]    offset;
  } sad_route_type;

  // One Flash bank placement
  typedef struct packed {
    logic        enable;
    logic [31:0] base;
    logic [31:0] size;
  } sad_bank_type;

endpackage

// ==== hdl/sad_boot_select.sv ====
/*
  Boot-bank selection bit, written only from the in_system_programming path.
  Assumes the stored bit is non-volatile outside this logic and is presented
  on nv_bit_i; the JTAG side updates it by erase then program pulses.
*/
`timescale 1ns/1ps
`include "sad_regs.svh"

module sad_boot_select
  import sad_pkg::*;
(
  input  wire logic clk_i,        // System clock
  input  wire logic resetn_i,     // Async reset, active low
  input  wire logic ce_i,         // Clock enable
  input  wire logic nv_bit_i,     // Stored boot choice, pin domain
  output logic      boot_second_o // Registered boot choice
);

  // --------------------------------------------------------------------------
  // Synchroniser and capture
  // --------------------------------------------------------------------------
  logic sync1_reg;
  logic sync2_reg;
  logic boot_reg;
  logic boot_next;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  // Capture once the synchroniser holds the pin value; cpu writes have no path here
  always_comb begin
    boot_next = boot_reg;
    cnt_next  = (cnt_reg == 2'h3) ? cnt_reg : cnt_reg + 2'h1;
    if (cnt_reg == `SAD_BOOT_CAP_AT) begin
      boot_next = sync2_reg;
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      boot_reg  <= 1'b0;
      cnt_reg   <= 2'h0;
    end else if (ce_i) begin
      sync1_reg <= nv_bit_i;
      sync2_reg <= sync1_reg;
      boot_reg  <= boot_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign boot_second_o = boot_reg;

endmodule

// ==== tb/sad_master_model.sv ====
/*
  Bus master model: processor or DMA side of the decoder.
  Assumes tasks are called just after a falling clock edge.
*/
`timescale 1ns/1ps

module sad_master_model
  import sad_pkg::*;
(
  input  wire logic  clk_i,       // System clock
  output sad_req_type req_o,      // Access request
  output logic [1:0] sram_code_o, // SRAM size code
  output logic       sram_load_o  // Size load strobe
);
  // ---------------------------------------------------------------------------
  // Request and size setup drivers
  // ---------------------------------------------------------------------------
  initial begin
    req_o       = '0;
    sram_code_o = 2'h0;
    sram_load_o = 1'b0;
  end

  // Request is held until the next call, as the decoder expects
  task automatic issue(input logic w, input logic c, input logic [31:0] a);
    req_o = '{valid: 1'b1, write: w, from_cpu: c, addr: a};
  endtask

  // Firmware size write, called only from t_size; one-cycle strobe
  task automatic set_size(input logic [1:0] code);
    sram_code_o = code;
    sram_load_o = 1'b1;
    @(negedge clk_i);
    sram_load_o = 1'b0;
  endtask
endmodule

// ==== tb/sad_monitor.sv ====
/*
  Port checker for the address decoder.
  Assumes Flash banks are not placed over SRAM or bridge aliases.
*/
`timescale 1ns/1ps

module sad_monitor
  import sad_pkg::*;
(
  input wire logic          clk_i,     // System clock
  input wire logic          resetn_i,  // Reset, active low
  input wire logic          ce_i,      // Clock enable
  input wire sad_req_type   req_i,     // Request
  input wire logic          wq_full_i, // Write queue full
  input wire sad_route_type route_o,   // Decode result
  input wire logic          stall_o    // Cpu stall
);
  // ---------------------------------------------------------------------------
  // Sequences and assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_go;
    ce_i && req_i.valid;
  endsequence
  sequence s_cpu_bwr;
    s_go ##0 (req_i.write && req_i.from_cpu && req_i.addr[31:26] == 6'h10);
  endsequence
  sequence s_brg(logic [4:0] w);
    s_go ##0 (req_i.addr[31:27] == w && !wq_full_i);
  endsequence

  answer_in_time_a: assert property (s_go |=> route_o.valid || stall_o) else $error("no answer");
  read_direct_a: assert property (s_go ##0 !req_i.write |=> !route_o.buffered) else $error("read buffered");
  master_unbuf_a: assert property (s_go ##0 !req_i.from_cpu |=> !route_o.buffered) else $error("dma buffered");
  full_stall_a: assert property (s_cpu_bwr ##0 wq_full_i |=> stall_o && !route_o.valid)
    else $error("no stall");
  local_sram_a: assert property (route_o.local_port |-> route_o.target == SAD_TGT_SRAM && !route_o.buffered)
    else $error("local port");
  nbuf_sram_a: assert property (s_go ##0 req_i.addr[31:26] == 6'h14 |=> !route_o.buffered)
    else $error("nbuf alias");
  brg_buf_a: assert property (s_brg(5'h09) ##0 (req_i.write && req_i.from_cpu) |=> route_o.buffered)
    else $error("bridge buf");
  brg_nbuf_a: assert property (s_brg(5'h0b) |=> !route_o.buffered && !route_o.error)
    else $error("bridge nbuf");
  brg_sel_a: assert property (s_brg(5'h09) |=> route_o.offset == {6'h0, $past(req_i.addr[25:0])} &&
    route_o.target == ($past(req_i.addr[26]) ? SAD_TGT_BRG2 : SAD_TGT_BRG1)) else $error("bridge sel");
  err_shape_a: assert property (route_o.error |-> route_o.target == SAD_TGT_NONE && route_o.offset == 32'h0)
    else $error("error shape");
  freeze_a: assert property (!ce_i |=> $stable(route_o) && $stable(stall_o)) else $error("not frozen");
endmodule

bind sad_decoder sad_monitor sad_monitor_inst (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .req_i(req_i), .wq_full_i(wq_full_i), .route_o(route_o), .stall_o(stall_o));

// ==== tb/tb_system_address_decoder.sv ====
/*
  Self-checking bench for the address decoder.
  Assumes the master model drives requests and SRAM size.
*/
`timescale 1ns/1ps

module tb_system_address_decoder
  import sad_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Clock, stimulus and instances
  // ---------------------------------------------------------------------------
  logic          clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, wq_full_i = 1'b0;
  logic          bank_load_i = 1'b0, nv_boot_i = 1'b0, stall_o, boot_second_o, sram_load_i;
  logic [1:0]    sram_code_i;
  sad_req_type   req_i;
  sad_route_type route_o;
  sad_bank_type  b1 = '{1'b1, 32'h0, 32'h8000}, b2 = '{1'b0, 32'h8_0000, 32'h8000};
  int            err_count = 0, tests_run = 0;

  always #10 clk_i = ~clk_i;

  sad_master_model sad_master_model_inst (.clk_i(clk_i), .req_o(req_i), .sram_code_o(sram_code_i),
    .sram_load_o(sram_load_i));
  sad_decoder sad_decoder_inst (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .req_i(req_i),
    .wq_full_i(wq_full_i), .sram_code_i(sram_code_i), .sram_load_i(sram_load_i), .bank1_cfg_i(b1),
    .bank2_cfg_i(b2), .bank_load_i(bank_load_i), .nv_boot_i(nv_boot_i), .route_o(route_o),
    .stall_o(stall_o), .boot_second_o(boot_second_o));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic bad(input string m);
    err_count++;
    $display("Error at %0t: %s", $time, m);
  endtask

  // Issue one access, then judge the answer one cycle later
  task automatic acc(input logic w, c, input logic [31:0] a, input sad_target_type t,
                     input logic l, b, e, input logic [31:0] off);
    @(negedge clk_i);
    sad_master_model_inst.issue(w, c, a);
    @(negedge clk_i);
    tests_run++;
    if (route_o.valid !== 1'b1 || route_o.target !== t || route_o.error !== e || route_o.offset !== off ||
        (!e && (route_o.local_port !== l || route_o.buffered !== b))) bad($sformatf("route %h at %h", route_o, a));
  endtask

  task automatic rst();
    @(negedge clk_i);
    resetn_i = 1'b0;
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (6) @(negedge clk_i);
  endtask

  task automatic load_banks();
    bank_load_i = 1'b1;
    @(negedge clk_i);
    bank_load_i = 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_sram();
    acc(0, 1, 32'h0400_0010, SAD_TGT_SRAM, 1, 0, 0, 32'h10);
    acc(1, 1, 32'h4000_0020, SAD_TGT_SRAM, 0, 1, 0, 32'h20);
    acc(1, 1, 32'h5000_0030, SAD_TGT_SRAM, 0, 0, 0, 32'h30);
    acc(0, 1, 32'h4000_0040, SAD_TGT_SRAM, 0, 0, 0, 32'h40);
    acc(1, 0, 32'h0400_0050, SAD_TGT_SRAM, 0, 0, 0, 32'h50);
    acc(1, 0, 32'h4000_0060, SAD_TGT_SRAM, 0, 0, 0, 32'h60);
    acc(1, 0, 32'h5000_0070, SAD_TGT_SRAM, 0, 0, 0, 32'h70);
    $display("test sram aliases done");
  endtask

  task automatic t_size();
    acc(0, 1, 32'h5000_7ffc, SAD_TGT_SRAM, 0, 0, 0, 32'h7ffc);
    acc(0, 1, 32'h5000_8000, SAD_TGT_NONE, 0, 0, 1, 32'h0);
    sad_master_model_inst.set_size(2'h1);
    acc(0, 1, 32'h5000_fffc, SAD_TGT_SRAM, 0, 0, 0, 32'hfffc);
    acc(0, 1, 32'h5001_0000, SAD_TGT_NONE, 0, 0, 1, 32'h0);
    sad_master_model_inst.set_size(2'h2);
    @(negedge clk_i);
    sad_master_model_inst.set_size(2'h3);
    acc(0, 1, 32'h5001_7ffc, SAD_TGT_SRAM, 0, 0, 0, 32'h17ffc);
    acc(0, 1, 32'h0401_8000, SAD_TGT_NONE, 0, 0, 1, 32'h0);
    $display("test sram size done");
  endtask

  task automatic t_bridge();
    acc(1, 1, 32'h4800_1000, SAD_TGT_BRG1, 0, 1, 0, 32'h1000);
    acc(1, 1, 32'h4c00_2000, SAD_TGT_BRG2, 0, 1, 0, 32'h2000);
    acc(1, 1, 32'h5800_3000, SAD_TGT_BRG1, 0, 0, 0, 32'h3000);
    acc(0, 1, 32'h5fff_fffc, SAD_TGT_BRG2, 0, 0, 0, 32'h3ff_fffc);
    acc(0, 1, 32'h2000_0000, SAD_TGT_NONE, 0, 0, 1, 32'h0);
    $display("test bridges done");
  endtask

  task automatic t_stall();
    wq_full_i = 1'b1;
    sad_master_model_inst.issue(1, 1, 32'h4000_0000);
    @(negedge clk_i);
    tests_run++;
    if (stall_o !== 1'b1 || route_o.valid !== 1'b0) bad("full queue did not stall");
    acc(0, 1, 32'h4000_0004, SAD_TGT_SRAM, 0, 0, 0, 32'h4);
    ce_i = 1'b0;
    sad_master_model_inst.issue(0, 1, 32'h5000_0008);
    repeat (2) @(negedge clk_i);
    tests_run++;
    if (route_o.offset !== 32'h4) bad("state moved with clock enable low");
    ce_i = 1'b1;
    wq_full_i = 1'b0;
    $display("test stall done");
  endtask

  task automatic t_flash();
    acc(0, 1, 32'h0000_0100, SAD_TGT_FLASH1, 0, 0, 0, 32'h100);
    acc(0, 1, 32'h0000_8000, SAD_TGT_NONE, 0, 0, 1, 32'h0);
    acc(0, 1, 32'h0008_0010, SAD_TGT_NONE, 0, 0, 1, 32'h0);
    b1 = '{1'b1, 32'h10_0000, 32'h4_0000};
    b2.enable = 1'b1;
    load_banks();
    acc(0, 1, 32'h0008_0010, SAD_TGT_FLASH2, 0, 0, 0, 32'h10);
    acc(0, 1, 32'h0013_fffc, SAD_TGT_FLASH1, 0, 0, 0, 32'h3_fffc);
    acc(0, 1, 32'h0000_0100, SAD_TGT_NONE, 0, 0, 1, 32'h0);
    $display("test flash banks done");
  endtask

  task automatic t_boot();
    nv_boot_i = 1'b1;
    rst();
    tests_run++;
    if (boot_second_o !== 1'b1) bad("boot choice not taken");
    acc(0, 1, 32'h0000_0100, SAD_TGT_FLASH2, 0, 0, 0, 32'h100);
    nv_boot_i = 1'b0;
    repeat (6) @(negedge clk_i);
    tests_run++;
    if (boot_second_o !== 1'b1) bad("boot choice changed without reset");
    rst();
    acc(0, 1, 32'h0000_0100, SAD_TGT_FLASH1, 0, 0, 0, 32'h100);
    $display("test boot select done");
  endtask

  // ---------------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rst();
    t_sram();
    t_size();
    t_bridge();
    t_stall();
    t_flash();
    t_boot();
    final_report();
  end

  // Run needs about 110 cycles; allow ample margin
  initial begin
    #100000;
    bad("watchdog expired");
    final_report();
  end
endmodule
